// ### core/cset2_pkg.sv
// constants for the core extension register block and timer 2
package cset2_pkg;
	localparam logic [7:0] CSET2_OFS_PTR_SEL   = 8'h86;
	localparam logic [7:0] CSET2_OFS_CLK_CTL   = 8'h8e;
	localparam logic [7:0] CSET2_OFS_SPC_SEL   = 8'h8f;
	localparam logic [7:0] CSET2_OFS_MEM_PAGE  = 8'h92;
	localparam logic [7:0] CSET2_OFS_T2_CTL    = 8'hc8;
	localparam logic [7:0] CSET2_OFS_T2_RLD_LO = 8'hca;
	localparam logic [7:0] CSET2_OFS_T2_RLD_HI = 8'hcb;
	localparam logic [7:0] CSET2_OFS_PTR0_LO   = 8'h82;
	localparam logic [7:0] CSET2_OFS_PTR0_HI   = 8'h83;
	localparam logic [7:0] CSET2_OFS_PTR1_LO   = 8'h84;
	localparam logic [7:0] CSET2_OFS_PTR1_HI   = 8'h85;
	localparam logic [7:0] CSET2_RST_PTR_SEL   = 8'h00;
	localparam logic [7:0] CSET2_RST_CLK_CTL   = 8'h01;
	localparam logic [7:0] CSET2_RST_SPC_SEL   = 8'h00;
	localparam logic [7:0] CSET2_RST_MEM_PAGE  = 8'h00;
	localparam logic [7:0] CSET2_RST_T2_CTL    = 8'h00;
	localparam logic [7:0] CSET2_RST_RLD       = 8'h00;
	localparam int CSET2_BIT_SEL   = 0;
	localparam int CSET2_BIT_T2_PRESC = 5;
	localparam int CSET2_BIT_T1_PRESC = 4;
	localparam int CSET2_BIT_T0_PRESC = 3;
	localparam int CSET2_BIT_WR_CHOICE = 0;
	localparam int CSET2_BIT_T2_OVF    = 7;
	localparam int CSET2_BIT_RXCLK     = 5;
	localparam int CSET2_BIT_TXCLK     = 4;
	localparam int CSET2_BIT_T2_RUN    = 2;
	localparam logic [7:0] CSET2_MSK_CLK_CTL = 8'h3f;
	localparam logic [7:0] CSET2_MSK_T2_CTL  = 8'hb4;
	localparam logic [7:0] CSET2_MSK_SEL     = 8'h01;
	localparam logic [3:0] CSET2_DIV_FAST    = 4'h4;
	localparam logic [3:0] CSET2_DIV_SLOW    = 4'hc;
	localparam logic [3:0] CSET2_DIV_BAUD    = 4'h2;
	localparam logic [3:0] CSET2_INSTR_CLKS  = 4'h4;
	localparam logic [15:0] CSET2_CNT_MAX    = 16'hffff;
endpackage

// ### core/cset2_presc.sv
// prescaler producing one tick every div clocks, or pass-through of an event in counter mode
`timescale 1ns/1ns
module cset2_presc (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// control
	input  wire logic [3:0] div_i,
	input  wire logic       count_mode_i,
	input  wire logic       event_i,
	// tick
	output logic            tick_o
);
	logic [3:0] cnt_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= 4'h0;
		end else if (cnt_r >= div_i - 4'h1) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	// counter mode ignores the divider entirely
	always_comb begin
		if (count_mode_i) begin
			tick_o = event_i;
		end else begin
			tick_o = (cnt_r >= div_i - 4'h1);
		end
	end
endmodule

// ### core/cset2_top.sv
// extension register bank: pointer select, timer clocks, strobe select, page, timer 2
`timescale 1ns/1ns
module cset2_top
	import cset2_pkg::*;
(
	// clock and reset
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_B_I,
	// register port from the core
	input  wire logic [7:0]  SFR_ADDR_I,
	input  wire logic        SFR_WR_I,
	input  wire logic [7:0]  SFR_WDATA_I,
	output logic      [7:0]  SFR_RDATA_O,
	// pointer updates from the core (increment etc.)
	input  wire logic        PTR_LOAD_I,
	input  wire logic [15:0] PTR_LOAD_VAL_I,
	output logic      [15:0] DATA_POINTER_O,
	// timers 0 and 1 and counter-mode events
	input  wire logic        T0_COUNT_MODE_I,
	input  wire logic        T1_COUNT_MODE_I,
	input  wire logic        T2_COUNT_MODE_I,
	input  wire logic        T0_EVENT_I,
	input  wire logic        T1_EVENT_I,
	input  wire logic        T2_EVENT_I,
	input  wire logic        T1_OVERFLOW_I,
	output logic             T0_TICK_O,
	output logic             T1_TICK_O,
	// external move support
	input  wire logic        EXT_MOVE_INDIRECT_I,
	input  wire logic [7:0]  PORT2_LATCH_I,
	output logic      [7:0]  ADDR_HIGH_O,
	output logic      [2:0]  STRETCH_O,
	input  wire logic        RAM_WR_I,
	output logic             MEM_WR_B_O,
	output logic             MEM_PSWR_B_O,
	// timer 2 results
	output logic             TIMER_TWO_PULSE_O,
	output logic             T2_IRQ_O,
	output logic             SER_RX_CLK_O,
	output logic             SER_TX_CLK_O
);
	import cset2_pkg::*;

	logic [7:0]  ptr_sel_r;
	logic [7:0]  clk_ctl_r;
	logic [7:0]  spc_sel_r;
	logic [7:0]  mem_page_r;
	logic [7:0]  t2_ctl_r;
	logic [7:0]  rld_lo_r;
	logic [7:0]  rld_hi_r;
	logic [15:0] ptr0_r;
	logic [15:0] ptr1_r;
	logic [15:0] t2_cnt_r;
	logic [15:0] t2_cnt_nxt;
	logic        t0_tick;
	logic        t1_tick;
	logic        t2_tick;
	logic        t2_baud;
	logic        t2_ovf;
	logic        sel_secondary;
	logic [3:0]  t2_div;

	function automatic logic wr_hit(input logic [7:0] ofs);
		return SFR_WR_I && (SFR_ADDR_I == ofs);
	endfunction

	function automatic logic [3:0] presc_div(input logic fast);
		return fast ? CSET2_DIV_FAST : CSET2_DIV_SLOW;
	endfunction

	assign sel_secondary = ptr_sel_r[CSET2_BIT_SEL];
	assign t2_baud = t2_ctl_r[CSET2_BIT_RXCLK] | t2_ctl_r[CSET2_BIT_TXCLK];
	// baud mode overrides the prescale bit
	assign t2_div = t2_baud ? CSET2_DIV_BAUD
		: presc_div(clk_ctl_r[CSET2_BIT_T2_PRESC]);
	assign t2_ovf = t2_tick && t2_ctl_r[CSET2_BIT_T2_RUN] && (t2_cnt_r == CSET2_CNT_MAX);

	cset2_presc u_t0 (
		.clk_i        (REF_CLK_I),
		.rst_b_i      (RST_B_I),
		.div_i        (presc_div(clk_ctl_r[CSET2_BIT_T0_PRESC])),
		.count_mode_i (T0_COUNT_MODE_I),
		.event_i      (T0_EVENT_I),
		.tick_o       (t0_tick)
	);
	cset2_presc u_t1 (
		.clk_i        (REF_CLK_I),
		.rst_b_i      (RST_B_I),
		.div_i        (presc_div(clk_ctl_r[CSET2_BIT_T1_PRESC])),
		.count_mode_i (T1_COUNT_MODE_I),
		.event_i      (T1_EVENT_I),
		.tick_o       (t1_tick)
	);
	cset2_presc u_t2 (
		.clk_i        (REF_CLK_I),
		.rst_b_i      (RST_B_I),
		.div_i        (t2_div),
		.count_mode_i (T2_COUNT_MODE_I & ~t2_baud),
		.event_i      (T2_EVENT_I),
		.tick_o       (t2_tick)
	);

	// simple control registers; reserved bits are masked off on write
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ptr_sel_r  <= CSET2_RST_PTR_SEL;
			clk_ctl_r  <= CSET2_RST_CLK_CTL;
			spc_sel_r  <= CSET2_RST_SPC_SEL;
			mem_page_r <= CSET2_RST_MEM_PAGE;
			rld_lo_r   <= CSET2_RST_RLD;
			rld_hi_r   <= CSET2_RST_RLD;
		end else begin
			if (wr_hit(CSET2_OFS_PTR_SEL)) begin
				ptr_sel_r <= SFR_WDATA_I & CSET2_MSK_SEL;
			end
			if (wr_hit(CSET2_OFS_CLK_CTL)) begin
				clk_ctl_r <= SFR_WDATA_I & CSET2_MSK_CLK_CTL;
			end
			if (wr_hit(CSET2_OFS_SPC_SEL)) begin
				spc_sel_r <= SFR_WDATA_I & CSET2_MSK_SEL;
			end
			if (wr_hit(CSET2_OFS_MEM_PAGE)) begin
				mem_page_r <= SFR_WDATA_I;
			end
			if (wr_hit(CSET2_OFS_T2_RLD_LO)) begin
				rld_lo_r <= SFR_WDATA_I;
			end
			if (wr_hit(CSET2_OFS_T2_RLD_HI)) begin
				rld_hi_r <= SFR_WDATA_I;
			end
		end
	end

	// both pointers; the core's load goes to whichever is selected
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ptr0_r <= 16'h0000;
			ptr1_r <= 16'h0000;
		end else begin
			if (PTR_LOAD_I && !sel_secondary) begin
				ptr0_r <= PTR_LOAD_VAL_I;
			end else if (wr_hit(CSET2_OFS_PTR0_LO)) begin
				ptr0_r[7:0] <= SFR_WDATA_I;
			end else if (wr_hit(CSET2_OFS_PTR0_HI)) begin
				ptr0_r[15:8] <= SFR_WDATA_I;
			end
			if (PTR_LOAD_I && sel_secondary) begin
				ptr1_r <= PTR_LOAD_VAL_I;
			end else if (wr_hit(CSET2_OFS_PTR1_LO)) begin
				ptr1_r[7:0] <= SFR_WDATA_I;
			end else if (wr_hit(CSET2_OFS_PTR1_HI)) begin
				ptr1_r[15:8] <= SFR_WDATA_I;
			end
		end
	end

	// timer 2 control; hardware set of the flag wins over a software clear
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			t2_ctl_r <= CSET2_RST_T2_CTL;
		end else if (t2_ovf && !t2_baud) begin
			t2_ctl_r[CSET2_BIT_T2_OVF] <= 1'b1;
			if (wr_hit(CSET2_OFS_T2_CTL)) begin
				t2_ctl_r[6:0] <= SFR_WDATA_I[6:0] & CSET2_MSK_T2_CTL[6:0];
			end
		end else if (wr_hit(CSET2_OFS_T2_CTL)) begin
			t2_ctl_r <= SFR_WDATA_I & CSET2_MSK_T2_CTL;
		end
	end

	// count and reload
	always_comb begin
		t2_cnt_nxt = t2_cnt_r;
		if (t2_tick && t2_ctl_r[CSET2_BIT_T2_RUN]) begin
			if (t2_ovf) begin
				t2_cnt_nxt = {rld_hi_r, rld_lo_r};
			end else begin
				t2_cnt_nxt = t2_cnt_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			t2_cnt_r <= 16'h0000;
		end else begin
			t2_cnt_r <= t2_cnt_nxt;
		end
	end

	// registered outputs
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			SFR_RDATA_O       <= 8'h00;
			DATA_POINTER_O    <= 16'h0000;
			T0_TICK_O         <= 1'b0;
			T1_TICK_O         <= 1'b0;
			ADDR_HIGH_O       <= 8'h00;
			STRETCH_O         <= 3'h0;
			MEM_WR_B_O        <= 1'b1;
			MEM_PSWR_B_O      <= 1'b1;
			TIMER_TWO_PULSE_O <= 1'b0;
			T2_IRQ_O          <= 1'b0;
			SER_RX_CLK_O      <= 1'b0;
			SER_TX_CLK_O      <= 1'b0;
		end else begin
			if (SFR_ADDR_I == CSET2_OFS_PTR_SEL) begin
				SFR_RDATA_O <= ptr_sel_r;
			end else if (SFR_ADDR_I == CSET2_OFS_CLK_CTL) begin
				SFR_RDATA_O <= clk_ctl_r;
			end else if (SFR_ADDR_I == CSET2_OFS_SPC_SEL) begin
				SFR_RDATA_O <= spc_sel_r;
			end else if (SFR_ADDR_I == CSET2_OFS_MEM_PAGE) begin
				SFR_RDATA_O <= mem_page_r;
			end else if (SFR_ADDR_I == CSET2_OFS_T2_CTL) begin
				SFR_RDATA_O <= t2_ctl_r;
			end else if (SFR_ADDR_I == CSET2_OFS_T2_RLD_LO) begin
				SFR_RDATA_O <= rld_lo_r;
			end else if (SFR_ADDR_I == CSET2_OFS_T2_RLD_HI) begin
				SFR_RDATA_O <= rld_hi_r;
			end else if (SFR_ADDR_I == CSET2_OFS_PTR0_LO) begin
				SFR_RDATA_O <= ptr0_r[7:0];
			end else if (SFR_ADDR_I == CSET2_OFS_PTR0_HI) begin
				SFR_RDATA_O <= ptr0_r[15:8];
			end else if (SFR_ADDR_I == CSET2_OFS_PTR1_LO) begin
				SFR_RDATA_O <= ptr1_r[7:0];
			end else if (SFR_ADDR_I == CSET2_OFS_PTR1_HI) begin
				SFR_RDATA_O <= ptr1_r[15:8];
			end else begin
				SFR_RDATA_O <= 8'h00;
			end
			DATA_POINTER_O    <= sel_secondary ? ptr1_r : ptr0_r;
			T0_TICK_O         <= t0_tick;
			T1_TICK_O         <= t1_tick;
			ADDR_HIGH_O       <= EXT_MOVE_INDIRECT_I ? mem_page_r : PORT2_LATCH_I;
			STRETCH_O         <= clk_ctl_r[2:0];
			MEM_WR_B_O        <= ~(RAM_WR_I & ~spc_sel_r[CSET2_BIT_WR_CHOICE]);
			MEM_PSWR_B_O      <= ~(RAM_WR_I & spc_sel_r[CSET2_BIT_WR_CHOICE]);
			TIMER_TWO_PULSE_O <= t2_ovf;
			T2_IRQ_O          <= t2_ctl_r[CSET2_BIT_T2_OVF];
			// serial clocks: timer 2 or timer 1 overflow per source bit
			SER_RX_CLK_O <= t2_ctl_r[CSET2_BIT_RXCLK] ? t2_ovf : T1_OVERFLOW_I;
			SER_TX_CLK_O <= t2_ctl_r[CSET2_BIT_TXCLK] ? t2_ovf : T1_OVERFLOW_I;
		end
	end
endmodule

// ### testbench/cset2_chk_checker.sv
// port assertions for the extension register block
`timescale 1ns/1ns
module cset2_chk (
	// watched ports
	input wire logic       REF_CLK_I,
	input wire logic       RST_B_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic       SFR_WR_I,
	input wire logic [7:0] SFR_WDATA_I,
	input wire logic [7:0] SFR_RDATA_O,
	input wire logic       EXT_MOVE_INDIRECT_I,
	input wire logic [7:0] PORT2_LATCH_I,
	input wire logic [7:0] ADDR_HIGH_O,
	input wire logic       RAM_WR_I,
	input wire logic       MEM_PSWR_B_O,
	input wire logic       T2_IRQ_O,
	input wire logic       T1_OVERFLOW_I,
	input wire logic       SER_RX_CLK_O
);
	logic [7:0] pg_r;
	logic [7:0] t2_r;
	logic [7:0] sp_r;
	wire        w8 = SFR_WR_I && SFR_ADDR_I == 8'hc8;
	// shadows of written values, so outputs can be tied to their cause
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			pg_r <= 8'h00;
			t2_r <= 8'h00;
			sp_r <= 8'h00;
		end else if (SFR_WR_I) begin
			if (SFR_ADDR_I == 8'h92) pg_r <= SFR_WDATA_I;
			if (SFR_ADDR_I == 8'hc8) t2_r <= SFR_WDATA_I;
			if (SFR_ADDR_I == 8'h8f) sp_r <= SFR_WDATA_I;
		end
	end
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_B_I);
	property p_hold; T2_IRQ_O && !w8 && !$past(w8) |=> T2_IRQ_O; endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_noset; (t2_r[5] || t2_r[4]) && !w8 && !$past(w8) |=> !$rose(T2_IRQ_O); endproperty
	a_noset: assert property (p_noset) else $error("flag set in baud mode");
	property p_rx; !t2_r[5] && T1_OVERFLOW_I |=> SER_RX_CLK_O; endproperty
	a_rx: assert property (p_rx) else $error("rx clock missing");
	property p_page; EXT_MOVE_INDIRECT_I |=> ADDR_HIGH_O == $past(pg_r); endproperty
	a_page: assert property (p_page) else $error("page not on address");
	property p_p2; !EXT_MOVE_INDIRECT_I |=> ADDR_HIGH_O == $past(PORT2_LATCH_I); endproperty
	a_p2: assert property (p_p2) else $error("latch not on address");
	property p_strobe1; RAM_WR_I && sp_r[0] |=> !MEM_PSWR_B_O; endproperty
	a_strobe1: assert property (p_strobe1) else $error("store strobe missing");
	property p_strobe0; RAM_WR_I && !sp_r[0] |=> MEM_PSWR_B_O; endproperty
	a_strobe0: assert property (p_strobe0) else $error("store strobe wrong");
	property p_rsv; SFR_ADDR_I inside {8'h86, 8'h8f} |=> SFR_RDATA_O[7:1] == 7'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule
bind cset2_top cset2_chk u_chk (.*);

// ### testbench/cset2_core_mdl.sv
// processor core model driving the register port
`timescale 1ns/1ns
module cset2_core_mdl
	import cset2_pkg::*;
(
	// clock and read data
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	// register port
	output logic      [7:0] addr_o,
	output logic            wr_o,
	output logic      [7:0] wdata_o
);
	initial begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		wdata_o = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		addr_o = a;
		wdata_o = (a == CSET2_OFS_T2_CTL) ? (d & CSET2_MSK_T2_CTL) : d;
		wr_o = 1'b1;
		@(posedge clk_i);
		#1;
		wr_o = 1'b0;
		// released data must not look like a held value
		wdata_o = ~wdata_o;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		addr_o = a;
		@(posedge clk_i);
		#1;
		d = rdata_i;
	endtask
endmodule

// ### testbench/cset2_top_tb.sv
// self-checking bench for the extension register block
`timescale 1ns/1ns
module cset2_top_tb;
	logic clk, rst_b, p_ld, c0, c2, e0, e2, t1ov, xmv, ramw, wr;
	logic [15:0] p_val, dp;
	logic [7:0] p2, sa, sd, rdat, ah, v;
	logic [2:0] st;
	logic t0t, t1t, wrb, pswrb, t2p, irq, rxc, txc;
	int n_mismatch, n_checks, cyc, n;
	cset2_top DUT (.REF_CLK_I(clk), .RST_B_I(rst_b), .SFR_ADDR_I(sa), .SFR_WR_I(wr),
		.SFR_WDATA_I(sd), .SFR_RDATA_O(rdat), .PTR_LOAD_I(p_ld), .PTR_LOAD_VAL_I(p_val),
		.DATA_POINTER_O(dp), .T0_COUNT_MODE_I(c0), .T1_COUNT_MODE_I(c0),
		.T2_COUNT_MODE_I(c2), .T0_EVENT_I(e0), .T1_EVENT_I(e0), .T2_EVENT_I(e2),
		.T1_OVERFLOW_I(t1ov), .T0_TICK_O(t0t), .T1_TICK_O(t1t), .EXT_MOVE_INDIRECT_I(xmv),
		.PORT2_LATCH_I(p2), .ADDR_HIGH_O(ah), .STRETCH_O(st), .RAM_WR_I(ramw),
		.MEM_WR_B_O(wrb), .MEM_PSWR_B_O(pswrb), .TIMER_TWO_PULSE_O(t2p), .T2_IRQ_O(irq),
		.SER_RX_CLK_O(rxc), .SER_TX_CLK_O(txc));
	cset2_core_mdl core (.clk_i(clk), .rdata_i(rdat), .addr_o(sa), .wr_o(wr), .wdata_o(sd));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		core.rd(a, v);
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, v});
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return t0t;
			1: return t1t;
			2: return t2p;
			3: return rxc;
			default: return txc;
		endcase
	endfunction
	// one-shot stimuli drop after the first edge
	task automatic cnt(input int k, input int c, output int m);
		m = 0;
		repeat (c) begin
			@(posedge clk);
			#1;
			{t1ov, e0} = 2'b00;
			m += int'(sig(k) === 1'b1);
		end
	endtask
	task automatic gap(input int k, output int g);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (sig(k) !== 1'b1 && i < 70000);
		g = 0;
		do begin
			@(posedge clk);
			#1;
			g++;
		end while (sig(k) !== 1'b1 && g < 70000);
	endtask
	task automatic t_regs();
		logic [7:0] a[5] = '{8'h86, 8'h8e, 8'h8f, 8'h92, 8'hca};
		logic [7:0] r[5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
		logic [7:0] m[5] = '{8'h01, 8'h3f, 8'h01, 8'hff, 8'hff};
		for (int i = 0; i < 5; i++) begin
			rdchk(a[i], r[i]);
			core.wr(a[i], 8'hff);
			rdchk(a[i], m[i]);
			core.wr(a[i], 8'h00);
		end
		rdchk(8'hc8, 8'h00);
		core.wr(8'h90, 8'hff);
		rdchk(8'h90, 8'h00);
		$display("t_regs done");
	endtask
	task automatic t_ptr();
		for (int i = 0; i < 4; i++) core.wr(8'(8'h82 + i), 8'(8'h11 * (i + 1)));
		rdchk(8'h85, 8'h44);
		chk("ptr", 16'h2211, dp);
		core.wr(8'h86, 8'h01);
		rdchk(8'h86, 8'h01);
		chk("ptr", 16'h4433, dp);
		p_ld = 1'b1;
		p_val = 16'hbeef;
		@(posedge clk);
		#1;
		p_ld = 1'b0;
		rdchk(8'h84, 8'hef);
		rdchk(8'h82, 8'h11);
		$display("t_ptr done");
	endtask
	task automatic t_tick();
		core.wr(8'h8e, 8'h0d);
		gap(0, n);
		chk("t0 gap", 16'h0004, 16'(n));
		gap(1, n);
		chk("t1 gap", 16'h000c, 16'(n));
		chk("stretch", 16'h0005, {13'h0, st});
		core.wr(8'h8e, 8'h10);
		gap(0, n);
		chk("t0 gap", 16'h000c, 16'(n));
		gap(1, n);
		chk("t1 gap", 16'h0004, 16'(n));
		core.wr(8'h8e, 8'h18);
		c0 = 1'b1;
		e0 = 1'b1;
		cnt(0, 20, n);
		chk("event ticks", 16'h0001, 16'(n));
		e0 = 1'b1;
		cnt(1, 20, n);
		chk("t1 event ticks", 16'h0001, 16'(n));
		c0 = 1'b0;
		$display("t_tick done");
	endtask
	task automatic t_t2();
		core.wr(8'hca, 8'hfe);
		core.wr(8'hcb, 8'hff);
		{c2, e2} = 2'b11;
		core.wr(8'hc8, 8'h04);
		gap(2, n);
		chk("t2 gap", 16'h0002, 16'(n));
		chk("flag", 16'h0001, {15'h0, irq});
		// this clear meets an overflow whose set wins; it stops the timer, the next clears
		core.wr(8'hc8, 8'h00);
		core.wr(8'hc8, 8'h00);
		cnt(2, 10, n);
		chk("stopped", 16'h0000, 16'(n));
		chk("flag", 16'h0000, {15'h0, irq});
		{c2, e2} = 2'b00;
		core.wr(8'h8e, 8'h20);
		core.wr(8'hc8, 8'h24);
		gap(3, n);
		chk("baud gap", 16'h0004, 16'(n));
		chk("flag", 16'h0000, {15'h0, irq});
		core.wr(8'hc8, 8'h80);
		cnt(2, 2, n);
		chk("flag", 16'h0001, {15'h0, irq});
		core.wr(8'hc8, 8'h00);
		t1ov = 1'b1;
		cnt(4, 3, n);
		chk("tx clk", 16'h0001, 16'(n));
		$display("t_t2 done");
	endtask
	task automatic t_mem();
		core.wr(8'h92, 8'ha5);
		core.wr(8'h8f, 8'h01);
		{xmv, ramw} = 2'b11;
		cnt(2, 2, n);
		chk("page", 16'h00a5, {8'h00, ah});
		chk("strobes", 16'h0001, {14'h0, pswrb, wrb});
		xmv = 1'b0;
		core.wr(8'h8f, 8'h00);
		cnt(2, 2, n);
		chk("latch", 16'h003c, {8'h00, ah});
		chk("strobes", 16'h0002, {14'h0, pswrb, wrb});
		ramw = 1'b0;
		$display("t_mem done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// run is about 66000 cycles, mostly the first timer 2 rollover
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		{p_ld, c0, c2, e0, e2, t1ov, xmv, ramw} = 8'h00;
		p_val = 16'h0000;
		p2 = 8'h3c;
		rst_b = 1'b0;
		repeat (12) @(posedge clk);
		#1;
		rst_b = 1'b1;
		t_regs();
		t_ptr();
		t_tick();
		t_mem();
		t_t2();
		test_done();
	end
endmodule
